// ===== verilog/gpamx_port_mux.sv
`timescale 1ns/1ps
module gpamx_port_mux
  import gpamx_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Software configuration and readback
  input  wire logic [7:0] pin_direction_bits_a,
  input  wire logic [7:0] pin_direction_bits_b,
  input  wire logic [7:0] pin_direction_bits_c,
  input  wire logic [7:0] alt_function_select_bits_a,
  input  wire logic [7:0] alt_function_select_bits_b,
  input  wire logic [7:0] alt_function_select_bits_c,
  input  wire logic [7:0] out_data_a,
  input  wire logic [7:0] out_data_b,
  input  wire logic [7:0] out_data_c,
  input  wire logic [7:0] open_drain_a,
  input  wire logic [7:0] open_drain_b,
  input  wire logic [7:0] open_drain_c,
  input  wire logic [7:0] irq_enable_a,
  input  wire logic [7:0] irq_enable_c,
  input  wire logic [7:0] irq_edge_fall_a,
  output      logic [7:0] port_input_value_a,
  output      logic [7:0] port_input_value_b,
  output      logic [7:0] port_input_value_c,
  output      logic [7:0] pin_irq_a,
  output      logic [7:0] pin_irq_c,
  // Pads: input, output, output enable (low = driving)
  input  wire logic [7:0] pad_in_a,
  input  wire logic [7:0] pad_in_b,
  input  wire logic [7:0] pad_in_c,
  output      logic [7:0] pad_out_a,
  output      logic [7:0] pad_out_b,
  output      logic [7:0] pad_out_c,
  output      logic [7:0] pad_oe_n_a,
  output      logic [7:0] pad_oe_n_b,
  output      logic [7:0] pad_oe_n_c,
  // Peripheral side
  input  wire logic       timer_zero_output,
  input  wire logic       uart_driver_enable,
  input  wire logic       uart_transmit,
  input  wire logic       infrared_transmit,
  input  wire logic       infrared_select,
  input  wire logic       i2c_clock_out,
  input  wire logic       i2c_data_out,
  input  wire logic       timer_one_output,
  input  wire logic       spi_master_mode,
  input  wire logic       spi_select_out,
  input  wire logic       spi_clock_out,
  input  wire logic       spi_mosi_out,
  input  wire logic       spi_miso_out,
  output      logic       timer_zero_input,
  output      logic       uart_clear_to_send,
  output      logic       uart_receive,
  output      logic       infrared_receive,
  output      logic       i2c_clock_in,
  output      logic       i2c_data_in,
  output      logic       timer_one_input,
  output      logic       spi_select_in,
  output      logic       spi_clock_in,
  output      logic       spi_mosi_in,
  output      logic       spi_miso_in,
  output      logic [4:0] analog_enable
);
  // ------------------------------------------------------------
  // Variant masks
  // ------------------------------------------------------------
  localparam logic [7:0] MASK_A = LARGE_PACKAGE ? LARGE_MASK_A : SMALL_MASK_A;
  localparam logic [7:0] MASK_B = LARGE_PACKAGE ? LARGE_MASK_B : SMALL_MASK_B;
  localparam logic [7:0] MASK_C = LARGE_PACKAGE ? LARGE_MASK_C : SMALL_MASK_C;

  gpamx_pin_if pin_a ();
  gpamx_pin_if pin_b ();
  gpamx_pin_if pin_c ();
  assign pin_a.pad_in = pad_in_a;
  assign pin_b.pad_in = pad_in_b;
  assign pin_c.pad_in = pad_in_c;

  gpamx_pad #(.MASK(MASK_A)) u_pad_a (.sys_clk(sys_clk), .reset(reset), .pins(pin_a.pad));
  gpamx_pad #(.MASK(MASK_B)) u_pad_b (.sys_clk(sys_clk), .reset(reset), .pins(pin_b.pad));
  gpamx_pad #(.MASK(MASK_C)) u_pad_c (.sys_clk(sys_clk), .reset(reset), .pins(pin_c.pad));

  // ------------------------------------------------------------
  // Peripheral drive and direction per pin (oe_n low = drive)
  // ------------------------------------------------------------
  logic [7:0] per_val_a, per_oe_n_a, per_val_c, per_oe_n_c;
  always_comb begin
    per_val_a  = 8'h00;
    per_oe_n_a = 8'hFF;
    per_val_a[PA_T0_OUT]  = timer_zero_output;
    per_oe_n_a[PA_T0_OUT] = 1'b0;
    per_val_a[PA_DE]      = uart_driver_enable;
    per_oe_n_a[PA_DE]     = 1'b0;
    per_val_a[PA_TX]      = infrared_select ? infrared_transmit : uart_transmit;
    per_oe_n_a[PA_TX]     = 1'b0;
    // I2C pins only ever pull low: open-drain regardless of config
    per_val_a[PA_SCL]     = 1'b0;
    per_oe_n_a[PA_SCL]    = i2c_clock_out;
    per_val_a[PA_SDA]     = 1'b0;
    per_oe_n_a[PA_SDA]    = i2c_data_out;
    per_val_c  = 8'h00;
    per_oe_n_c = 8'hFF;
    per_val_c[PC_T1_OUT]  = timer_one_output;
    per_oe_n_c[PC_T1_OUT] = 1'b0;
    // SPI direction follows master/slave role
    per_val_c[PC_SS]      = spi_select_out;
    per_oe_n_c[PC_SS]     = ~spi_master_mode;
    per_val_c[PC_SCK]     = spi_clock_out;
    per_oe_n_c[PC_SCK]    = ~spi_master_mode;
    per_val_c[PC_MOSI]    = spi_mosi_out;
    per_oe_n_c[PC_MOSI]   = ~spi_master_mode;
    per_val_c[PC_MISO]    = spi_miso_out;
    per_oe_n_c[PC_MISO]   = spi_master_mode;
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  logic [7:0] next_out_a, next_out_b, next_out_c;
  logic [7:0] next_oe_a,  next_oe_b,  next_oe_c;
  logic [7:0] drv_out_a,  drv_out_b,  drv_out_c;
  logic [7:0] drv_oe_a,   drv_oe_b,   drv_oe_c;

  function automatic logic [15:0] pin_drive(input logic [7:0] dir, input logic [7:0] alt,
                                            input logic [7:0] dat, input logic [7:0] od,
                                            input logic [7:0] pval, input logic [7:0] poe_n,
                                            input logic [7:0] mask);
    logic [7:0] val;
    logic [7:0] oe_n;
    val  = 8'h00;
    oe_n = 8'hFF;
    for (int i = 0; i < PORT_WIDTH; i++) begin
      if (alt[i]) begin
        val[i]  = pval[i];
        oe_n[i] = poe_n[i];
      end else begin
        val[i]  = dat[i];
        oe_n[i] = dir[i];
      end
      if (od[i] && val[i] && !oe_n[i]) begin
        oe_n[i] = 1'b1;
      end
      if (!mask[i]) begin
        oe_n[i] = 1'b1;
      end
    end
    return {val, oe_n};
  endfunction

  always_comb begin
    {next_out_a, next_oe_a} = pin_drive(pin_direction_bits_a, alt_function_select_bits_a, out_data_a,
                                        open_drain_a, per_val_a, per_oe_n_a, MASK_A);
    // Analog pins: driver held off under alternate function
    {next_out_b, next_oe_b} = pin_drive(pin_direction_bits_b, alt_function_select_bits_b, out_data_b,
                                        open_drain_b, 8'h00, 8'hFF, MASK_B);
    {next_out_c, next_oe_c} = pin_drive(pin_direction_bits_c, alt_function_select_bits_c, out_data_c,
                                        open_drain_c, per_val_c, per_oe_n_c, MASK_C);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      drv_out_a <= OUT_RESET;
      drv_out_b <= OUT_RESET;
      drv_out_c <= OUT_RESET;
      drv_oe_a  <= DIR_RESET;
      drv_oe_b  <= DIR_RESET;
      drv_oe_c  <= DIR_RESET;
    end else begin
      drv_out_a <= next_out_a;
      drv_out_b <= next_out_b;
      drv_out_c <= next_out_c;
      drv_oe_a  <= next_oe_a;
      drv_oe_b  <= next_oe_b;
      drv_oe_c  <= next_oe_c;
    end
  end

  assign pad_out_a  = drv_out_a;
  assign pad_out_b  = drv_out_b;
  assign pad_out_c  = drv_out_c;
  assign pad_oe_n_a = drv_oe_a;
  assign pad_oe_n_b = drv_oe_b;
  assign pad_oe_n_c = drv_oe_c;
  assign pin_a.drive_value = drv_out_a;
  assign pin_b.drive_value = drv_out_b;
  assign pin_c.drive_value = drv_out_c;
  assign pin_a.drive_oe_n  = drv_oe_a;
  assign pin_b.drive_oe_n  = drv_oe_b;
  assign pin_c.drive_oe_n  = drv_oe_c;

  // ------------------------------------------------------------
  // Inputs to software and peripherals
  // ------------------------------------------------------------
  assign port_input_value_a = pin_a.sampled;
  assign port_input_value_b = pin_b.sampled;
  assign port_input_value_c = pin_c.sampled;

  assign timer_zero_input   = alt_function_select_bits_a[PA_T0_IN] & pin_a.sampled[PA_T0_IN];
  assign uart_clear_to_send = alt_function_select_bits_a[PA_CTS] & pin_a.sampled[PA_CTS];
  assign uart_receive       = alt_function_select_bits_a[PA_RX] & ~infrared_select & pin_a.sampled[PA_RX];
  assign infrared_receive   = alt_function_select_bits_a[PA_RX] & infrared_select & pin_a.sampled[PA_RX];
  // Idle-high buses read high when not selected
  assign i2c_clock_in       = ~alt_function_select_bits_a[PA_SCL] | pin_a.sampled[PA_SCL];
  assign i2c_data_in        = ~alt_function_select_bits_a[PA_SDA] | pin_a.sampled[PA_SDA];
  assign timer_one_input    = alt_function_select_bits_c[PC_T1_IN] & pin_c.sampled[PC_T1_IN];
  assign spi_select_in      = ~alt_function_select_bits_c[PC_SS] | pin_c.sampled[PC_SS];
  assign spi_clock_in       = alt_function_select_bits_c[PC_SCK] & pin_c.sampled[PC_SCK];
  assign spi_mosi_in        = alt_function_select_bits_c[PC_MOSI] & pin_c.sampled[PC_MOSI];
  assign spi_miso_in        = alt_function_select_bits_c[PC_MISO] & pin_c.sampled[PC_MISO];
  assign analog_enable      = alt_function_select_bits_b[4:0] & MASK_B[4:0];

  // ------------------------------------------------------------
  // Pin interrupts: port A on selected edge, port C on any edge
  // ------------------------------------------------------------
  logic [7:0] next_irq_a, next_irq_c, irq_a, irq_c;
  always_comb begin
    for (int i = 0; i < PORT_WIDTH; i++) begin
      next_irq_a[i] = irq_enable_a[i] & pin_a.edge_seen[i] &
                      (irq_edge_fall_a[i] ? pin_a.sampled[i] : ~pin_a.sampled[i]);
    end
    next_irq_c = irq_enable_c & pin_c.edge_seen;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_a <= 8'h00;
      irq_c <= 8'h00;
    end else begin
      irq_a <= next_irq_a;
      irq_c <= next_irq_c;
    end
  end
  assign pin_irq_a = irq_a;
  assign pin_irq_c = irq_c;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence normal_out_s(int i);
    !alt_function_select_bits_a[i] && !pin_direction_bits_a[i] && !open_drain_a[i];
  endsequence
  normal_drive_a: assert property (@(posedge sys_clk) disable iff (reset)
    normal_out_s(0) |=> !pad_oe_n_a[0] && pad_out_a[0] == $past(out_data_a[0]))
    else $error("normal output not driven");
  input_tristate_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!alt_function_select_bits_c[0] && pin_direction_bits_c[0]) |=> pad_oe_n_c[0])
    else $error("input pin driven");
  alt_override_a: assert property (@(posedge sys_clk) disable iff (reset)
    (alt_function_select_bits_a[PA_T0_OUT] && pin_direction_bits_a[PA_T0_OUT] && !open_drain_a[PA_T0_OUT]) |=>
    !pad_oe_n_a[PA_T0_OUT] && pad_out_a[PA_T0_OUT] == $past(timer_zero_output))
    else $error("alternate direction ignored");
  i2c_opendrain_a: assert property (@(posedge sys_clk) disable iff (reset)
    alt_function_select_bits_a[PA_SDA] |=> (pad_oe_n_a[PA_SDA] == $past(i2c_data_out)) && !pad_out_a[PA_SDA])
    else $error("I2C pin not open-drain");
  analog_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    alt_function_select_bits_b[0] |=> pad_oe_n_b[0])
    else $error("analog pin driven");
  mosi_master_a: assert property (@(posedge sys_clk) disable iff (reset)
    (alt_function_select_bits_c[PC_MOSI] && spi_master_mode && MASK_C[PC_MOSI] && !open_drain_c[PC_MOSI])
    |=> !pad_oe_n_c[PC_MOSI])
    else $error("MOSI not driven");
  any_edge_a: assert property (@(posedge sys_clk) disable iff (reset)
    (irq_enable_c[0] && pin_c.edge_seen[0]) |=> pin_irq_c[0])
    else $error("edge interrupt missed");
  rise_only_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!$past(irq_edge_fall_a[0]) && $fell(pin_a.sampled[0])) |-> !pin_irq_a[0])
    else $error("rise interrupt on fall");
  unimpl_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
    ((drv_oe_b | MASK_B) == 8'hFF) && ((drv_oe_c | MASK_C) == 8'hFF))
    else $error("unimplemented pin driven");
endmodule // gpamx_port_mux

// ===== verilog/gpamx_pkg.sv
package gpamx_pkg;
  // ------------------------------------------------------------
  // Port geometry
  // ------------------------------------------------------------
  localparam int PORT_WIDTH  = 8;
  localparam int MAX_PINS    = 19;
  // Implemented pin masks per package variant
  localparam logic [7:0] SMALL_MASK_A = 8'hFF;
  localparam logic [7:0] SMALL_MASK_B = 8'h03;
  localparam logic [7:0] SMALL_MASK_C = 8'h01;
  localparam logic [7:0] LARGE_MASK_A = 8'hFF;
  localparam logic [7:0] LARGE_MASK_B = 8'h1F;
  localparam logic [7:0] LARGE_MASK_C = 8'h3F;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] ALT_RESET = 8'h00;
  localparam logic [7:0] OUT_RESET = 8'h00;
  // ------------------------------------------------------------
  // Pin positions of alternate functions
  // ------------------------------------------------------------
  localparam int PA_T0_IN   = 0;
  localparam int PA_T0_OUT  = 1;
  localparam int PA_DE      = 2;
  localparam int PA_CTS     = 3;
  localparam int PA_RX      = 4;
  localparam int PA_TX      = 5;
  localparam int PA_SCL     = 6;
  localparam int PA_SDA     = 7;
  localparam int PC_T1_IN   = 0;
  localparam int PC_T1_OUT  = 1;
  localparam int PC_SS      = 2;
  localparam int PC_SCK     = 3;
  localparam int PC_MOSI    = 4;
  localparam int PC_MISO    = 5;
  localparam int PB_ANALOG  = 5;
  // Edge selection code
  typedef enum logic {GPAMX_RISE, GPAMX_FALL} gpamx_edge_t;
endpackage

// ===== verilog/gpamx_pin_if.sv
`timescale 1ns/1ps
// Per-port bundle between the mux core and the pad stage
interface gpamx_pin_if;
  logic [7:0] pad_in;
  logic [7:0] drive_value;
  logic [7:0] drive_oe_n;
  logic [7:0] sampled;
  logic [7:0] edge_seen;
  modport core (output drive_value, output drive_oe_n, input sampled, input edge_seen, output pad_in);
  modport pad  (input drive_value, input drive_oe_n, output sampled, output edge_seen, input pad_in);
endinterface

// ===== verilog/gpamx_pad.sv
`timescale 1ns/1ps
// Samples one port and detects edges on each pin.
module gpamx_pad
  import gpamx_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hFF
) (
  input  wire logic      sys_clk,
  input  wire logic      reset,
  gpamx_pin_if.pad       pins
);
  logic [7:0] sampled_q;
  logic [7:0] next_sampled;
  logic       armed;
  logic       next_armed;

  always_comb begin
    next_sampled = pins.pad_in & MASK;
    next_armed   = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sampled_q <= 8'h00;
      armed     <= 1'b0;
    end else begin
      sampled_q <= next_sampled;
      armed     <= next_armed;
    end
  end

  // Pulled-up pins would look like a rise against the reset sample; wait for one real sample
  assign pins.sampled   = sampled_q;
  assign pins.edge_seen = armed ? ((sampled_q ^ next_sampled) & MASK) : 8'h00;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  unimpl_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    (sampled_q & ~MASK) == 8'h00) else $error("unimplemented pin sampled nonzero");
  reset_edge_a: assert property (@(posedge sys_clk)
    $past(reset) |-> pins.edge_seen == 8'h00) else $error("edge reported right after reset");
endmodule // gpamx_pad

// ===== dv/gpamx_pad_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Board side of one port
// ------------------------------------------------------------
module gpamx_pad_model (
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] ext_value,
  input  wire logic [7:0] ext_drive,
  output      logic [7:0] pad_in
);
  // Device driver wins; otherwise the board drives or the pull-up holds high
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_drive[i]) begin
        pad_in[i] = ext_value[i];
      end else begin
        pad_in[i] = 1'b1;
      end
    end
  end
endmodule // gpamx_pad_model

// ===== dv/gpio_port_alt_function_mux_test.sv
`timescale 1ns/1ps
module gpio_port_alt_function_mux_test;
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] pin_direction_bits_a, pin_direction_bits_b, pin_direction_bits_c;
  logic [7:0] alt_function_select_bits_a, alt_function_select_bits_b, alt_function_select_bits_c;
  logic [7:0] out_data_a, out_data_b, out_data_c, open_drain_a, open_drain_b, open_drain_c;
  logic [7:0] irq_enable_a, irq_enable_c, irq_edge_fall_a, port_input_value_a, port_input_value_b;
  logic [7:0] port_input_value_c, pin_irq_a, pin_irq_c, pad_in_a, pad_in_b, pad_in_c;
  logic [7:0] pad_out_a, pad_out_b, pad_out_c, pad_oe_n_a, pad_oe_n_b, pad_oe_n_c;
  logic [7:0] ev_a, ev_b, ev_c, ed_a, ed_b, ed_c;
  logic       timer_zero_output, uart_driver_enable, uart_transmit, infrared_transmit, infrared_select;
  logic       i2c_clock_out, i2c_data_out, timer_one_output, spi_master_mode, spi_select_out;
  logic       spi_clock_out, spi_mosi_out, spi_miso_out, timer_zero_input, uart_clear_to_send;
  logic       uart_receive, infrared_receive, i2c_clock_in, i2c_data_in, timer_one_input;
  logic       spi_select_in, spi_clock_in, spi_mosi_in, spi_miso_in;
  logic [4:0] analog_enable;
  logic [7:0] small_in_b, small_in_c, small_oe_n_b, small_oe_n_c;
  logic [4:0] small_analog;
  int         n_fail = 0;
  int         n_tests = 0;

  always #4 sys_clk = ~sys_clk;

  gpamx_port_mux #(.LARGE_PACKAGE(1'b1)) gpamx_port_mux_i (
    .sys_clk, .reset, .pin_direction_bits_a, .pin_direction_bits_b, .pin_direction_bits_c,
    .alt_function_select_bits_a, .alt_function_select_bits_b, .alt_function_select_bits_c,
    .out_data_a, .out_data_b, .out_data_c, .open_drain_a, .open_drain_b, .open_drain_c,
    .irq_enable_a, .irq_enable_c, .irq_edge_fall_a, .port_input_value_a, .port_input_value_b,
    .port_input_value_c, .pin_irq_a, .pin_irq_c, .pad_in_a, .pad_in_b, .pad_in_c,
    .pad_out_a, .pad_out_b, .pad_out_c, .pad_oe_n_a, .pad_oe_n_b, .pad_oe_n_c,
    .timer_zero_output, .uart_driver_enable, .uart_transmit, .infrared_transmit, .infrared_select,
    .i2c_clock_out, .i2c_data_out, .timer_one_output, .spi_master_mode, .spi_select_out,
    .spi_clock_out, .spi_mosi_out, .spi_miso_out, .timer_zero_input, .uart_clear_to_send,
    .uart_receive, .infrared_receive, .i2c_clock_in, .i2c_data_in, .timer_one_input,
    .spi_select_in, .spi_clock_in, .spi_mosi_in, .spi_miso_in, .analog_enable);

  // Small package variant shares the stimulus; only its masked outputs are judged
  gpamx_port_mux #(.LARGE_PACKAGE(1'b0)) gpamx_port_mux_small_i (
    .sys_clk, .reset, .pin_direction_bits_a, .pin_direction_bits_b, .pin_direction_bits_c,
    .alt_function_select_bits_a, .alt_function_select_bits_b, .alt_function_select_bits_c,
    .out_data_a, .out_data_b, .out_data_c, .open_drain_a, .open_drain_b, .open_drain_c,
    .irq_enable_a, .irq_enable_c, .irq_edge_fall_a, .port_input_value_a(), .port_input_value_b(small_in_b),
    .port_input_value_c(small_in_c), .pin_irq_a(), .pin_irq_c(), .pad_in_a, .pad_in_b, .pad_in_c,
    .pad_out_a(), .pad_out_b(), .pad_out_c(), .pad_oe_n_a(), .pad_oe_n_b(small_oe_n_b), .pad_oe_n_c(small_oe_n_c),
    .timer_zero_output, .uart_driver_enable, .uart_transmit, .infrared_transmit, .infrared_select,
    .i2c_clock_out, .i2c_data_out, .timer_one_output, .spi_master_mode, .spi_select_out,
    .spi_clock_out, .spi_mosi_out, .spi_miso_out, .timer_zero_input(), .uart_clear_to_send(),
    .uart_receive(), .infrared_receive(), .i2c_clock_in(), .i2c_data_in(), .timer_one_input(),
    .spi_select_in(), .spi_clock_in(), .spi_mosi_in(), .spi_miso_in(), .analog_enable(small_analog));

  gpamx_pad_model gpamx_pad_model_a_i (.pad_out(pad_out_a), .pad_oe_n(pad_oe_n_a), .ext_value(ev_a),
                                      .ext_drive(ed_a), .pad_in(pad_in_a));
  gpamx_pad_model gpamx_pad_model_b_i (.pad_out(pad_out_b), .pad_oe_n(pad_oe_n_b), .ext_value(ev_b),
                                      .ext_drive(ed_b), .pad_in(pad_in_b));
  gpamx_pad_model gpamx_pad_model_c_i (.pad_out(pad_out_c), .pad_oe_n(pad_oe_n_c), .ext_value(ev_c),
                                      .ext_drive(ed_c), .pad_in(pad_in_c));

  // ------------------------------------------------------------
  // Compare and closing tasks
  // ------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Registered outputs need one edge; three leave margin for the sample stage
  task automatic settle;
    repeat (3) @(negedge sys_clk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic normal_io;
    pin_direction_bits_a = 8'h00;
    out_data_a = 8'hA5;
    open_drain_a = 8'h01;
    settle();
    chk8(pad_oe_n_a, 8'h01);
    chk8(pad_out_a & 8'hFE, 8'hA4);
    chk8(port_input_value_a, 8'hA5);
    pin_direction_bits_a = 8'hFF;
    open_drain_a = 8'h00;
    ev_a = 8'h3C; ev_b = 8'hFF; ev_c = 8'hFF;
    ed_a = 8'hFF; ed_b = 8'hFF; ed_c = 8'hFF;
    settle();
    chk8(pad_oe_n_a, 8'hFF);
    chk8(port_input_value_a, 8'h3C);
    chk8(port_input_value_b, 8'h1F);
    chk8(port_input_value_c, 8'h3F);
    chk8(small_in_b, 8'h03);
    chk8(small_in_c, 8'h01);
  endtask

  task automatic alt_port_a;
    // Direction says input; the peripherals must still drive their pins
    pin_direction_bits_a = 8'hFF;
    alt_function_select_bits_a = 8'hFF;
    timer_zero_output = 1'b1; uart_driver_enable = 1'b0; uart_transmit = 1'b1;
    i2c_clock_out = 1'b0; i2c_data_out = 1'b1;
    ev_a = 8'h19; ed_a = 8'h19;
    settle();
    chk8(pad_oe_n_a, 8'h99);
    chk8(pad_out_a & 8'h66, 8'h22);
    chk1(timer_zero_input, 1'b1);
    chk1(uart_clear_to_send, 1'b1);
    chk1(uart_receive, 1'b1);
    chk1(i2c_clock_in, 1'b0);
    chk1(i2c_data_in, 1'b1);
    infrared_select = 1'b1; infrared_transmit = 1'b0; i2c_clock_out = 1'b1;
    settle();
    chk8(pad_oe_n_a, 8'hD9);
    chk1(pad_out_a[5], 1'b0);
    chk1(infrared_receive, 1'b1);
    alt_function_select_bits_a = 8'h00;
    pin_direction_bits_a = 8'h00;
    out_data_a = 8'h00;
    settle();
    chk8(pad_oe_n_a, 8'h00);
    chk1(timer_zero_input, 1'b0);
  endtask

  task automatic alt_port_c_b;
    pin_direction_bits_c = 8'h00;
    alt_function_select_bits_c = 8'h3F;
    spi_master_mode = 1'b1; timer_one_output = 1'b0; spi_select_out = 1'b0;
    spi_clock_out = 1'b1; spi_mosi_out = 1'b1;
    ev_c = 8'h21; ed_c = 8'h21;
    settle();
    chk8(pad_oe_n_c, 8'hE1);
    chk8(pad_out_c & 8'h1E, 8'h18);
    chk1(timer_one_input, 1'b1);
    chk1(spi_miso_in, 1'b1);
    chk1(spi_clock_in, 1'b1);
    spi_master_mode = 1'b0; spi_miso_out = 1'b0; ed_c = 8'h15;
    settle();
    chk8(pad_oe_n_c, 8'hDD);
    chk8(small_oe_n_c, 8'hFF);
    chk1(pad_out_c[5], 1'b0);
    chk1(spi_select_in, 1'b0);
    chk1(spi_mosi_in, 1'b0);
    pin_direction_bits_b = 8'h00;
    out_data_b = 8'hFF;
    settle();
    chk8(pad_oe_n_b, 8'hE0);
    chk8(pad_out_b & 8'h1F, 8'h1F);
    chk8(small_oe_n_b, 8'hFC);
    alt_function_select_bits_b = 8'hFF;
    settle();
    chk8(pad_oe_n_b, 8'hFF);
    chk8({3'h0, analog_enable}, 8'h1F);
    chk8({3'h0, small_analog}, 8'h03);
  endtask

  // Drives one pad level change and counts irq pulses over a short window
  task automatic pulse(input bit on_c, input logic [7:0] val, input int exp);
    int cnt;
    cnt = 0;
    if (on_c) ev_c = val;
    else ev_a = val;
    repeat (6) begin
      @(negedge sys_clk);
      if ((on_c ? pin_irq_c : pin_irq_a) !== 8'h00) cnt++;
    end
    chk8(cnt[7:0], exp[7:0]);
  endtask

  task automatic pin_irqs;
    pin_direction_bits_a = 8'hFF; pin_direction_bits_c = 8'hFF;
    alt_function_select_bits_a = 8'h00; alt_function_select_bits_c = 8'h00;
    ev_a = 8'h00; ev_c = 8'h00; ed_a = 8'hFF; ed_c = 8'hFF;
    irq_enable_a = 8'h01; irq_enable_c = 8'h01; irq_edge_fall_a = 8'h00;
    settle();
    pulse(1'b0, 8'h01, 1);
    pulse(1'b0, 8'h00, 0);
    irq_edge_fall_a = 8'h01;
    settle();
    pulse(1'b0, 8'h01, 0);
    pulse(1'b0, 8'h00, 1);
    pulse(1'b0, 8'h02, 0);
    pulse(1'b1, 8'h01, 1);
    pulse(1'b1, 8'h00, 1);
    pulse(1'b1, 8'h02, 0);
  endtask

  initial begin
    pin_direction_bits_a = 8'hFF; pin_direction_bits_b = 8'hFF; pin_direction_bits_c = 8'hFF;
    alt_function_select_bits_a = 8'h00; alt_function_select_bits_b = 8'h00;
    alt_function_select_bits_c = 8'h00; out_data_a = 8'h00; out_data_b = 8'h00; out_data_c = 8'h00;
    open_drain_a = 8'h00; open_drain_b = 8'h00; open_drain_c = 8'h00;
    // Enabled through reset so a false edge against the reset sample would show
    irq_enable_a = 8'h00; irq_enable_c = 8'h01; irq_edge_fall_a = 8'h00;
    ev_a = 8'h00; ev_b = 8'h00; ev_c = 8'h00; ed_a = 8'h00; ed_b = 8'h00; ed_c = 8'h00;
    timer_zero_output = 1'b0; uart_driver_enable = 1'b0; uart_transmit = 1'b0; infrared_transmit = 1'b0;
    infrared_select = 1'b0; i2c_clock_out = 1'b1; i2c_data_out = 1'b1; timer_one_output = 1'b0;
    spi_master_mode = 1'b0; spi_select_out = 1'b1; spi_clock_out = 1'b0; spi_mosi_out = 1'b0;
    spi_miso_out = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk8(pad_oe_n_a & pad_oe_n_b & pad_oe_n_c, 8'hFF);
    chk8(pin_irq_a | pin_irq_c, 8'h00);
    reset = 1'b0;
    @(negedge sys_clk);
    chk8(pin_irq_c, 8'h00);
    @(negedge sys_clk);
    chk8(pin_irq_c, 8'h00);
    normal_io();
    alt_port_a();
    alt_port_c_b();
    pin_irqs();
    complete_run();
  end

  // Whole sequence needs under a hundred cycles
  initial begin
    #80000;
    n_fail++;
    complete_run();
  end
endmodule // gpio_port_alt_function_mux_test
